// ### scsi_map.vh
`ifndef SCSI_MAP_VH
`define SCSI_MAP_VH
`define SCSI_ADDR_SEL 16'hfe00
`define SCSI_ADDR_IRQ 16'hfe01
`define SCSI_ADDR_IEN 16'hfe02
`define SCSI_SEL_RESET 8'h00
`define SCSI_IRQ_RESET 8'h00
`define SCSI_IEN_RESET 8'h00
`define SCSI_SEL_LO 2
`define SCSI_BYP_BIT 1
`define SCSI_CNT_IRQ_BIT 7
`define SCSI_SEL_NONE 2'b00
`define SCSI_SEL_EXT 2'b01
`define SCSI_SEL_INT 2'b10
`define SCSI_SEL_WMASK 8'h0e
`endif

// ### scsi_len_counter.v
`timescale 1ns/1ps
// Bit-length counter clocked by card clock falling edges, sampled on clk.
module scsi_len_counter #(
  parameter W = 8
) (
  input wire clk,
  input wire reset_n,
  input wire load,
  input wire [W-1:0] load_value,
  input wire card_clk,
  output reg [W-1:0] count_reg,
  output reg [W-1:0] max_reg,
  output reg hit_pulse_reg
);
  reg card_clk_d_reg;
  reg running_reg;
  wire fall;
  assign fall = card_clk_d_reg & ~card_clk;
  always @(posedge clk) begin
    if (!reset_n) begin
      card_clk_d_reg <= 1'b0;
      count_reg <= {W{1'b0}};
      max_reg <= {W{1'b0}};
      running_reg <= 1'b0;
      hit_pulse_reg <= 1'b0;
    end else begin
      card_clk_d_reg <= card_clk;
      hit_pulse_reg <= 1'b0;
      if (load) begin
        max_reg <= load_value;
        count_reg <= {W{1'b0}};
        running_reg <= (load_value != {W{1'b0}});
      end else if (running_reg && fall) begin
        count_reg <= count_reg + 1'b1; // RULE11
        if (count_reg + 1'b1 == max_reg) begin
          running_reg <= 1'b0;
          hit_pulse_reg <= 1'b1; // RULE11
        end
      end
    end
  end
endmodule

// ### scsi_select_irq.v
`timescale 1ns/1ps
`include "scsi_map.vh"
// Function
// RULE1: Select field bits 3:2 route UART: 00 none, 01 external, 1X internal.
// RULE2: Writing the select field never powers or activates a card interface.
// RULE3: Bypass bit 1 drives card I/O from control register data/direction.
// RULE4: Reading the interrupt status register clears its bits.
// RULE5: Each cause is masked by its matching interrupt enable bit.
// RULE6: Status reports only the currently selected interface's conditions.
// RULE7: Firmware does all error processing; hardware only reports errors.
// RULE8: Firmware stops card clock with stop level high before start bit.
// RULE9: Firmware drives data low with direction output to form start bit.
// RULE10: Firmware ensures TX FIFO has data before restarting card clock.
// RULE11: Counter counts card clock falls after load 1..255, interrupts at value.
// RULE12: At terminal or zero with direct-line mode, I/O follows control bits.
// RULE13: Select bits 7:4 and 0 read zero and ignore writes.
module scsi_select_irq #(
  parameter AW = 16
) (
  input wire clk,
  input wire reset_n,
  input wire [AW-1:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata_reg,
  input wire [7:0] int_cause,
  input wire [7:0] ext_cause,
  input wire int_data_bit,
  input wire int_io_direction_bit,
  input wire ext_data_bit,
  input wire ext_io_direction_bit,
  input wire direct_line_mode,
  input wire uart_io_out,
  input wire uart_io_oe,
  input wire len_load,
  input wire [7:0] len_value,
  input wire card_clk,
  output reg int_io_out_reg,
  output reg int_io_oe_reg,
  output reg external_card_io_out_reg,
  output reg external_card_io_oe_reg,
  output reg [1:0] uart_route_reg,
  output reg irq_reg
);
  reg [7:0] sel_reg;
  reg [7:0] sts_reg;
  reg [7:0] ien_reg;
  reg [7:0] sts_next;
  reg [7:0] cause;
  reg dir_out;
  reg dir_oe;
  reg io_out;
  reg io_oe;
  wire [7:0] len_count;
  wire [7:0] len_max;
  wire len_hit;
  wire [1:0] field;
  wire direct;
  wire at_end;
  wire wr_sel;
  wire wr_ien;
  wire rd_sts;
  wire int_sel;
  wire ext_sel;
  reg [7:0] sfr_rdata_next;
  reg int_io_out_next;
  reg int_io_oe_next;
  reg ext_io_out_next;
  reg ext_io_oe_next;
  reg [1:0] uart_route_next;
  reg irq_next;

  // Address match for one register of the bank.
  function addr_is;
    input [AW-1:0] addr;
    input [AW-1:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  // Field code 1X picks the internal interface.
  function pick_int;
    input [1:0] f;
    begin
      pick_int = f[1];
    end
  endfunction

  // Field code 01 picks the external interface.
  function pick_ext;
    input [1:0] f;
    begin
      pick_ext = (f == `SCSI_SEL_EXT);
    end
  endfunction

  // Route code folds both internal codes onto one value.
  function [1:0] route_code;
    input [1:0] f;
    begin
      if (pick_int(f)) begin
        route_code = `SCSI_SEL_INT;
      end else begin
        route_code = f;
      end
    end
  endfunction

  scsi_len_counter #(.W(8)) u_len (
    .clk(clk),
    .reset_n(reset_n),
    .load(len_load),
    .load_value(len_value),
    .card_clk(card_clk),
    .count_reg(len_count),
    .max_reg(len_max),
    .hit_pulse_reg(len_hit)
  );

  assign field = sel_reg[`SCSI_SEL_LO+1:`SCSI_SEL_LO];
  assign int_sel = pick_int(field);
  assign ext_sel = pick_ext(field);
  assign wr_sel = sfr_wr & addr_is(sfr_addr, `SCSI_ADDR_SEL);
  assign wr_ien = sfr_wr & addr_is(sfr_addr, `SCSI_ADDR_IEN);
  assign rd_sts = sfr_rd & addr_is(sfr_addr, `SCSI_ADDR_IRQ);
  assign at_end = (len_max == 8'h00) || (len_count == len_max);
  assign direct = sel_reg[`SCSI_BYP_BIT] | (at_end & direct_line_mode);

  // Causes from the selected interface only, plus the counter hit on bit 7; none selected reports only the counter hit.
  always @* begin
    if (int_sel) begin
      cause = int_cause; // RULE6
    end else if (ext_sel) begin
      cause = ext_cause; // RULE6
    end else begin
      cause = 8'h00;
    end
    cause[`SCSI_CNT_IRQ_BIT] = cause[`SCSI_CNT_IRQ_BIT] | len_hit; // RULE11
  end

  // Set wins over the read clear.
  always @* begin
    sts_next = sts_reg;
    if (rd_sts) begin
      sts_next = 8'h00; // RULE4
    end
    sts_next = sts_next | cause;
  end

  // Line source: control bits in bypass, or in direct-line mode at counter end or zero length, else the UART.
  always @* begin
    if (int_sel) begin
      dir_out = int_data_bit;
      dir_oe = int_io_direction_bit;
    end else begin
      dir_out = ext_data_bit;
      dir_oe = ext_io_direction_bit;
    end
    if (direct) begin
      io_out = dir_out; // RULE3 RULE12
      io_oe = dir_oe; // RULE3 RULE12
    end else begin
      io_out = uart_io_out;
      io_oe = uart_io_oe;
    end
  end

  // Read data holds between reads; unmapped addresses read as zero.
  always @* begin
    sfr_rdata_next = sfr_rdata_reg;
    if (sfr_rd) begin
      case (sfr_addr)
        `SCSI_ADDR_SEL: sfr_rdata_next = sel_reg; // RULE13
        `SCSI_ADDR_IRQ: sfr_rdata_next = sts_reg; // RULE4
        `SCSI_ADDR_IEN: sfr_rdata_next = ien_reg;
        default: sfr_rdata_next = 8'h00;
      endcase
    end
  end

  // Only the selected interface sees the line; the other one idles high.
  always @* begin
    int_io_out_next = 1'b1;
    int_io_oe_next = 1'b0;
    ext_io_out_next = 1'b1;
    ext_io_oe_next = 1'b0;
    if (int_sel) begin
      int_io_out_next = io_out; // RULE1
      int_io_oe_next = io_oe;
    end else if (ext_sel) begin
      ext_io_out_next = io_out; // RULE1
      ext_io_oe_next = io_oe;
    end
  end

  // Interrupt follows the freshly updated status; route follows the registered field.
  always @* begin
    irq_next = |(sts_next & ien_reg); // RULE5
    uart_route_next = route_code(field); // RULE1
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      sel_reg <= `SCSI_SEL_RESET;
      sts_reg <= `SCSI_IRQ_RESET;
      ien_reg <= `SCSI_IEN_RESET;
      sfr_rdata_reg <= 8'h00;
      int_io_out_reg <= 1'b1;
      int_io_oe_reg <= 1'b0;
      external_card_io_out_reg <= 1'b1;
      external_card_io_oe_reg <= 1'b0;
      uart_route_reg <= `SCSI_SEL_NONE;
      irq_reg <= 1'b0;
    end else begin
      if (wr_sel) begin
        sel_reg <= sfr_wdata & `SCSI_SEL_WMASK; // RULE13 RULE2
      end
      if (wr_ien) begin
        ien_reg <= sfr_wdata;
      end
      sts_reg <= sts_next;
      irq_reg <= irq_next;
      uart_route_reg <= uart_route_next;
      sfr_rdata_reg <= sfr_rdata_next;
      int_io_out_reg <= int_io_out_next;
      int_io_oe_reg <= int_io_oe_next;
      external_card_io_out_reg <= ext_io_out_next;
      external_card_io_oe_reg <= ext_io_oe_next;
    end
  end
endmodule

// ### scsi_asserts.sv
`timescale 1ns/1ps
module scsi_asserts (
  input wire clk,
  input wire reset_n,
  input wire [15:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] int_cause,
  input wire [7:0] ext_cause,
  input wire [7:0] sfr_rdata_reg,
  input wire int_io_oe_reg,
  input wire external_card_io_oe_reg,
  input wire [1:0] uart_route_reg,
  input wire irq_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire ws = sfr_wr && sfr_addr == 16'hfe00;
  wire rs = sfr_rd && sfr_addr == 16'hfe01;
  wire quiet = int_cause == 8'h00 && ext_cause == 8'h00;
  reg [1:0] rt;
  always @(posedge clk)
    if (ws) rt <= sfr_wdata[3] ? 2'h2 : {1'b0, sfr_wdata[2]};
  sequence two_rd;
    (rs && quiet) ##1 quiet ##1 rs;
  endsequence
  chk_route_field: assert property (
    ws |-> ##2 uart_route_reg == rt) else $error("route");
  chk_sel_unused: assert property (
    sfr_rd && sfr_addr == 16'hfe00 |=>
    sfr_rdata_reg[7:4] == 4'h0 && !sfr_rdata_reg[0]) else $error("sel");
  chk_status_clear: assert property (
    two_rd |=> sfr_rdata_reg[6:0] == 7'h00) else $error("clear");
  chk_irq_mask: assert property (
    sfr_wr && sfr_addr == 16'hfe02 && sfr_wdata == 8'h00 |-> ##2 !irq_reg)
    else $error("mask");
  chk_ext_idle: assert property (
    (uart_route_reg == 2'h2) [*2] |-> !external_card_io_oe_reg)
    else $error("ext");
  chk_int_idle: assert property (
    (uart_route_reg == 2'h1) [*2] |-> !int_io_oe_reg) else $error("int");
  chk_rdata_hold: assert property (
    !sfr_rd |=> $stable(sfr_rdata_reg)) else $error("hold");
  chk_unmapped_rd: assert property (
    sfr_rd && sfr_addr > 16'hfe02 |=> sfr_rdata_reg == 8'h00)
    else $error("unmapped");
endmodule

// ### scsi_card_model.sv
`timescale 1ns/1ps
module scsi_card_model (
  input wire clk,
  input wire run,
  output wire card_clk
);
  reg [1:0] ph = 2'h0;
  // The card clock stands still high outside frames.
  always @(posedge clk) ph <= run ? ph + 2'h1 : 2'h0;
  assign card_clk = ~ph[1];
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 0, reset_n = 0, sfr_wr = 0, sfr_rd = 0, run = 0;
  logic [15:0] sfr_addr = 0;
  logic [7:0] sfr_wdata = 0, int_cause = 0, ext_cause = 0, len_value = 0;
  logic int_data_bit = 1, int_io_direction_bit = 0, ext_data_bit = 1;
  logic ext_io_direction_bit = 0, direct_line_mode = 0, uart_io_out = 1;
  logic uart_io_oe = 0, len_load = 0, card_clk, irq_reg;
  logic [7:0] sfr_rdata_reg;
  logic int_io_out_reg, int_io_oe_reg, external_card_io_out_reg;
  logic external_card_io_oe_reg;
  logic [1:0] uart_route_reg;
  wire [7:0] ext_line;
  wire [7:0] int_line;
  assign ext_line = {6'h00, external_card_io_out_reg,
    external_card_io_oe_reg};
  assign int_line = {6'h00, int_io_out_reg, int_io_oe_reg};
  int err_count = 0, samples_checked = 0;
  scsi_select_irq i_dut (.*);
  scsi_card_model i_card (.*);
  initial forever #12.5 clk = ~clk;
  task finish_test;
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %0t got %h want %h", $time, s, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    cyc(1);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_rd = !w;
    cyc(1);
    sfr_wr = 0;
    sfr_rd = 0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    acc(0, a, 8'h00);
    chk(sfr_rdata_reg, e);
  endtask
  initial begin
    #100000;
    err_count++;
    finish_test;
  end
  initial begin
    cyc(8);
    reset_n = 1;
    rd(16'hfe00, 8'h00);
    rd(16'hfe01, 8'h00);
    acc(1, 16'hfe00, 8'hff);
    rd(16'hfe00, 8'h0e);
    chk({6'h00, uart_route_reg}, 8'h02);
    chk({6'h00, int_io_oe_reg, external_card_io_oe_reg}, 8'h00);
    acc(1, 16'hfe00, 8'h04);
    ext_cause = 8'h04;
    int_cause = 8'h02;
    cyc(1);
    ext_cause = 8'h00;
    int_cause = 8'h00;
    rd(16'hfe01, 8'h04);
    rd(16'hfe01, 8'h00);
    acc(1, 16'hfe02, 8'h04);
    ext_cause = 8'h04;
    cyc(1);
    ext_cause = 8'h00;
    cyc(2);
    chk({7'h00, irq_reg}, 8'h01);
    acc(1, 16'hfe02, 8'h00);
    cyc(1);
    chk({7'h00, irq_reg}, 8'h00);
    rd(16'hfe01, 8'h04);
    len_value = 8'h03;
    len_load = 1;
    cyc(1);
    len_load = 0;
    run = 1;
    cyc(12);
    run = 0;
    cyc(2);
    rd(16'hfe01, 8'h80);
    uart_io_oe = 1;
    cyc(2);
    chk(ext_line, 8'h03);
    chk(int_line, 8'h02);
    ext_data_bit = 0;
    ext_io_direction_bit = 1;
    direct_line_mode = 1;
    cyc(2);
    chk(ext_line, 8'h01);
    len_value = 8'h02;
    len_load = 1;
    cyc(1);
    len_load = 0;
    cyc(2);
    chk(ext_line, 8'h03);
    run = 1;
    cyc(8);
    run = 0;
    chk(ext_line, 8'h01);
    rd(16'hfe01, 8'h80);
    direct_line_mode = 0;
    uart_io_oe = 0;
    int_data_bit = 0;
    int_io_direction_bit = 1;
    acc(1, 16'hfe00, 8'h0a);
    cyc(1);
    chk({6'h00, int_io_out_reg, int_io_oe_reg}, 8'h01);
    chk(ext_line, 8'h02);
    rd(16'hfe04, 8'h00);
    finish_test;
  end
endmodule
bind scsi_select_irq scsi_asserts i_chk (.*);
